// ===== fecs_pkg.sv
package fecs_pkg;
    // flash pin widths
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;

    // command codes and unlock addresses
    localparam logic [18:0] UNLOCK_ADDR_A = 19'h00555;
    localparam logic [18:0] UNLOCK_ADDR_B = 19'h002aa;
    localparam logic [7:0]  CODE_UNLOCK_A = 8'haa;
    localparam logic [7:0]  CODE_UNLOCK_B = 8'h55;
    localparam logic [7:0]  CODE_SETUP    = 8'h80;
    localparam logic [7:0]  CODE_CHIP     = 8'h10;
    localparam logic [7:0]  CODE_SECTOR   = 8'h30;
    localparam logic [7:0]  CODE_SUSPEND  = 8'hb0;
    localparam logic [7:0]  CODE_RESUME   = 8'h30;
    localparam logic [7:0]  CODE_BYP_PROG = 8'ha0;
    localparam logic [7:0]  CODE_BYP_X1   = 8'h90;
    localparam logic [7:0]  CODE_BYP_X2   = 8'h00;

    // erase_window_flag position in the status byte
    localparam int WINDOW_FLAG_BIT = 3;

    // timing
    localparam int CLK_MHZ         = 250;
    localparam int WINDOW_US       = 50;
    // gap between sector adds kept well inside the window: 40 us
    localparam int ADD_GAP_US      = 40;
    localparam int ADD_GAP_CYC     = ADD_GAP_US * CLK_MHZ;
    localparam int WINDOW_CYC      = WINDOW_US * CLK_MHZ;
    localparam int SUSPEND_US      = 20;
    localparam int SUSPEND_CYC     = SUSPEND_US * CLK_MHZ;
    // strobe timing in clock cycles (4 ns each)
    localparam int SETUP_CYC       = 3;
    localparam int PULSE_CYC       = 12;
    localparam int HOLD_CYC        = 3;
    localparam int READ_CYC        = 25;

    // wishbone register offsets (byte addresses)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_SECTOR = 4'h4;
    localparam logic [3:0] REG_DATA   = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;

    // operation codes in ctrl[3:0]
    localparam logic [3:0] OP_CHIP_ERASE = 4'h1;
    localparam logic [3:0] OP_SECT_ERASE = 4'h2;
    localparam logic [3:0] OP_ADD_SECTOR = 4'h3;
    localparam logic [3:0] OP_SUSPEND    = 4'h4;
    localparam logic [3:0] OP_RESUME     = 4'h5;
    localparam logic [3:0] OP_BYP_PROG   = 4'h6;
    localparam logic [3:0] OP_BYP_EXIT   = 4'h7;
    localparam logic [3:0] OP_READ       = 4'h8;
    localparam logic [3:0] OP_WRITE_RAW  = 4'h9;
endpackage

// ===== fecs_host.sv
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module fecs_host
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // flash pins
    output logic      [18:0] flash_addr_o,
    output logic      [7:0]  flash_dq_o,
    output logic             flash_dq_oe_o,
    input  wire logic [7:0]  flash_dq_i,
    output logic             flash_ce_n_o,
    output logic             flash_we_n_o,
    output logic             flash_oe_n_o
);
    typedef enum logic [4:0]
    {
        ST_IDLE  = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_PULSE = 5'b00100,
        ST_HOLD  = 5'b01000,
        ST_READ  = 5'b10000
    } fecs_state_t;

    fecs_state_t state;
    logic [3:0]  op;
    logic [18:0] sector;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [2:0]  step;
    logic [2:0]  nsteps;
    logic [15:0] cnt;
    logic [15:0] gap_cnt;
    logic        busy;
    logic        late;
    logic [7:0]  dq_s1;
    logic [7:0]  dq_s2;
    logic [18:0] cyc_addr;
    logic [7:0]  cyc_data;

    // address and data of erase sequence cycle n (0..5)
    function automatic logic [26:0] erase_cycle(input logic [2:0] n, input logic [7:0] last,
                                                input logic [18:0] last_addr);
        unique case (n)
            3'd0, 3'd3: erase_cycle = {fecs_pkg::UNLOCK_ADDR_A, fecs_pkg::CODE_UNLOCK_A};
            3'd1, 3'd4: erase_cycle = {fecs_pkg::UNLOCK_ADDR_B, fecs_pkg::CODE_UNLOCK_B};
            3'd2:       erase_cycle = {fecs_pkg::UNLOCK_ADDR_A, fecs_pkg::CODE_SETUP};
            default:    erase_cycle = {last_addr, last};
        endcase
    endfunction

    localparam logic [15:0] GAP_MAX  = 16'(fecs_pkg::ADD_GAP_CYC);

    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // current bus cycle content
    always_comb
    begin
        cyc_addr = 19'h00000;
        cyc_data = 8'h00;
        unique case (op)
            fecs_pkg::OP_CHIP_ERASE:
                {cyc_addr, cyc_data} = erase_cycle(3'd5 - step, fecs_pkg::CODE_CHIP,
                                                   fecs_pkg::UNLOCK_ADDR_A);
            fecs_pkg::OP_SECT_ERASE:
                {cyc_addr, cyc_data} = erase_cycle(3'd5 - step, fecs_pkg::CODE_SECTOR,
                                                   sector);
            fecs_pkg::OP_ADD_SECTOR:
                {cyc_addr, cyc_data} = {sector, fecs_pkg::CODE_SECTOR};
            fecs_pkg::OP_SUSPEND:
                {cyc_addr, cyc_data} = {19'h00000, fecs_pkg::CODE_SUSPEND};
            fecs_pkg::OP_RESUME:
                {cyc_addr, cyc_data} = {19'h00000, fecs_pkg::CODE_RESUME};
            fecs_pkg::OP_BYP_PROG:
                {cyc_addr, cyc_data} = (step == 3'd1) ? {19'h00000, fecs_pkg::CODE_BYP_PROG}
                                                      : {sector, wdata};
            fecs_pkg::OP_BYP_EXIT:
                {cyc_addr, cyc_data} = (step == 3'd1) ? {19'h00000, fecs_pkg::CODE_BYP_X1}
                                                      : {19'h00000, fecs_pkg::CODE_BYP_X2};
            default:
                {cyc_addr, cyc_data} = {sector, wdata};
        endcase
    end

    always_comb
    begin
        unique case (wb_dat_i[3:0])
            fecs_pkg::OP_CHIP_ERASE, fecs_pkg::OP_SECT_ERASE: nsteps = 3'd6;
            fecs_pkg::OP_BYP_PROG, fecs_pkg::OP_BYP_EXIT:     nsteps = 3'd2;
            default:                                          nsteps = 3'd1;
        endcase
    end

    // bus side: accepts an operation only when idle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    fecs_pkg::REG_CTRL:   wb_dat_o <= {28'h0000000, op};
                    fecs_pkg::REG_SECTOR: wb_dat_o <= {13'h0000, sector};
                    fecs_pkg::REG_DATA:   wb_dat_o <= {24'h000000, rdata};
                    fecs_pkg::REG_STATUS: wb_dat_o <= {28'h0000000, rdata[fecs_pkg::WINDOW_FLAG_BIT],
                                                       late, 1'b0, busy};
                    default:              wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sector <= 19'h00000;
            wdata  <= 8'h00;
        end
        else if (wb_req && wb_we_i && !busy)
        begin
            if (wb_adr_i == fecs_pkg::REG_SECTOR && wb_sel_i[0])
                sector <= wb_dat_i[18:0];
            if (wb_adr_i == fecs_pkg::REG_DATA && wb_sel_i[0])
                wdata <= wb_dat_i[7:0];
        end
    end

    // gap since last completed strobe, flags a late sector add
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gap_cnt <= 16'hffff;
            late    <= 1'b0;
        end
        else
        begin
            if (state == ST_HOLD)
                gap_cnt <= 16'h0000;
            else if (gap_cnt != 16'hffff)
                gap_cnt <= gap_cnt + 16'h0001;
            if (wb_req && wb_we_i && !busy && wb_adr_i == fecs_pkg::REG_CTRL)
                late <= (wb_dat_i[3:0] == fecs_pkg::OP_ADD_SECTOR) && (gap_cnt > GAP_MAX);
        end
    end

    always_ff @(posedge clk_i)
    begin
        dq_s1 <= flash_dq_i;
        dq_s2 <= dq_s1;
    end

    // pin sequencer: one write strobe per step, all cycles back to back
    // so sector adds never stall mid sequence
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= ST_IDLE;
            op    <= 4'h0;
            step  <= 3'd0;
            cnt   <= 16'h0000;
            busy  <= 1'b0;
            rdata <= 8'h00;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (wb_req && wb_we_i && wb_adr_i == fecs_pkg::REG_CTRL && wb_sel_i[0]
                        && !busy)
                    begin
                        op    <= wb_dat_i[3:0];
                        step  <= nsteps - 3'd1;
                        busy  <= 1'b1;
                        cnt   <= 16'h0000;
                        state <= (wb_dat_i[3:0] == fecs_pkg::OP_READ) ? ST_READ : ST_SETUP;
                    end
                    else
                        busy <= 1'b0;
                ST_SETUP:
                begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == 16'(fecs_pkg::SETUP_CYC - 1))
                    begin
                        cnt   <= 16'h0000;
                        state <= ST_PULSE;
                    end
                end
                ST_PULSE:
                begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == 16'(fecs_pkg::PULSE_CYC - 1))
                    begin
                        cnt   <= 16'h0000;
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == 16'(fecs_pkg::HOLD_CYC - 1))
                    begin
                        cnt <= 16'h0000;
                        if (step == 3'd0)
                            state <= ST_IDLE;
                        else
                        begin
                            // steps count down, first cycle holds nsteps-1
                            step  <= step - 3'd1;
                            state <= ST_SETUP;
                        end
                    end
                end
                ST_READ:
                begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == 16'(fecs_pkg::READ_CYC - 1))
                    begin
                        rdata <= dq_s2;
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flash_addr_o  <= 19'h00000;
            flash_dq_o    <= 8'h00;
            flash_dq_oe_o <= 1'b0;
            flash_ce_n_o  <= 1'b1;
            flash_we_n_o  <= 1'b1;
            flash_oe_n_o  <= 1'b1;
        end
        else
        begin
            flash_ce_n_o  <= !(state == ST_SETUP || state == ST_PULSE || state == ST_READ);
            flash_we_n_o  <= !(state == ST_PULSE);
            flash_oe_n_o  <= !(state == ST_READ);
            flash_dq_oe_o <= (state == ST_SETUP || state == ST_PULSE || state == ST_HOLD);
            flash_addr_o  <= (state == ST_READ) ? sector : cyc_addr;
            flash_dq_o    <= cyc_data;
        end
    end
endmodule

// ===== fecs_host_properties.sv
`timescale 1ns/1ps
module fecs_host_chk
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // bus handshake
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    // flash pins
    input wire logic [18:0] flash_addr_o,
    input wire logic [7:0]  flash_dq_o,
    input wire logic        flash_dq_oe_o,
    input wire logic        flash_ce_n_o,
    input wire logic        flash_we_n_o,
    input wire logic        flash_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence we_low12;
        !flash_we_n_o [*8] ##1 !flash_we_n_o [*4] ##1 flash_we_n_o;
    endsequence
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_after_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    we_pulse_len_a: assert property ($fell(flash_we_n_o) |-> we_low12)
        else $error("write strobe length wrong");
    addr_held_a: assert property (!flash_we_n_o && $past(!flash_we_n_o)
        |-> $stable(flash_addr_o) && $stable(flash_dq_o))
        else $error("address or data moved in strobe");
    write_drive_a: assert property (!flash_we_n_o |-> flash_dq_oe_o && !flash_ce_n_o)
        else $error("write without drive or select");
    no_contend_a: assert property (!flash_oe_n_o |-> !flash_dq_oe_o && flash_we_n_o)
        else $error("read while driving");
    strobe_gap_a: assert property ($rose(flash_we_n_o) |-> flash_we_n_o [*3])
        else $error("strobe gap too short");
    setup_first_a: assert property ($fell(flash_we_n_o) |-> $past(flash_dq_oe_o, 2))
        else $error("data not set up");
endmodule

bind fecs_host fecs_host_chk fecs_host_chk_inst
(
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .flash_ce_n_o(flash_ce_n_o),
    .flash_we_n_o(flash_we_n_o), .flash_oe_n_o(flash_oe_n_o)
);

// ===== fecs_flash_model.sv
`timescale 1ns/1ps
module fecs_flash_model
(
    // host pins
    input  wire logic [18:0] addr_i,
    input  wire logic [7:0]  dq_i,
    input  wire logic        ce_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    // read data
    output logic      [7:0]  dq_o
);
    localparam int WIN_NS = 50000;
    logic [18:0] la[$];
    logic [7:0]  ld[$];
    logic [18:0] a_lat;
    logic [26:0] want;
    logic [7:0]  held = 8'h00;
    int          step = 0;
    // only a strobe that really fell counts; reset edges from x are ignored
    bit          armed = 1'b0;
    // mode 0 read, 1 window, 2 erasing, 3 suspended
    int          mode = 0;
    time         t_last = 0;
    always @(negedge we_n_i or negedge ce_n_i)
        if (!we_n_i && !ce_n_i)
        begin
            a_lat = addr_i;
            armed = 1'b1;
        end
    always @(posedge we_n_i)
    if (armed)
    begin
        armed = 1'b0;
        la.push_back(a_lat);
        ld.push_back(dq_i);
        want = (step == 1 || step == 4) ? 27'h02aa55 : (step == 2 ? 27'h055580 : 27'h0555aa);
        if (mode == 1 && $time - t_last > WIN_NS)
            mode = 2;
        if (mode == 1 && dq_i == 8'h30)
            t_last = $time;
        else if ((mode == 1 || mode == 2) && dq_i == 8'hb0)
            mode = 3;
        else if (mode == 3 && dq_i == 8'h30)
            mode = 2;
        else if (mode == 1)
            mode = 0;
        else if (mode != 0)
            step = 0;
        else if (step == 5 && {a_lat, dq_i} == 27'h055510)
            step = 0;
        else if (step == 5 && dq_i == 8'h30)
        begin
            mode = 1;
            t_last = $time;
            step = 0;
        end
        else if ({a_lat, dq_i} == want && step < 5)
            step++;
        else
            step = 0;
    end
    // released bus shows the inverse of its last value, not a stale match
    always @*
        if (!ce_n_i && !oe_n_i)
            dq_o = mode == 0 ? addr_i[7:0] ^ 8'h5a
                 : {mode == 3, 3'h0, mode != 1 || $time - t_last > WIN_NS, 3'h0};
        else
            dq_o = ~held;
    always @(posedge oe_n_i)
        held = dq_o;
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic        wb_ack_o, dq_oe, ce_n, we_n, oe_n;
    logic [18:0] addr, sect;
    logic [7:0]  dq_h, dq_m, val;
    wire  [7:0]  dq_w = dq_oe ? dq_h : dq_m;
    logic [27:0] exp_q[$], e;
    int          bad_count = 0, checks_done = 0, lp = 0;
    always #2 clk_i = ~clk_i;
    fecs_host fecs_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_addr_o(addr),
        .flash_dq_o(dq_h), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_w), .flash_ce_n_o(ce_n),
        .flash_we_n_o(we_n), .flash_oe_n_o(oe_n));
    fecs_flash_model fecs_flash_model_inst (.addr_i(addr), .dq_i(dq_w), .ce_n_i(ce_n),
        .we_n_i(we_n), .oe_n_i(oe_n), .dq_o(dq_m));
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 40);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 40)
        begin
            bad_count++;
            end_sim();
        end
    endtask
    // x set means the address is not looked at
    task ex(input logic x, input logic [18:0] a, input logic [7:0] d);
        exp_q.push_back({x, a, d});
    endtask
    task op(input logic [3:0] code, input int w);
        int n;
        wb(1'b1, fecs_pkg::REG_CTRL, {28'h0, code});
        for (n = 0; n < 500 && (n == 0 || q[0] !== 1'b0); n++)
            wb(1'b0, fecs_pkg::REG_STATUS, 32'h0);
        chk({31'h0, q[0]}, 32'h0);
        while (exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            if (e[27])
                e[26:8] = fecs_flash_model_inst.la[lp];
            chk({fecs_flash_model_inst.la[lp], fecs_flash_model_inst.ld[lp]}, {5'h0, e[26:0]});
            lp++;
        end
        chk(32'(fecs_flash_model_inst.la.size()), 32'(lp));
        if (w)
            wb(1'b0, fecs_pkg::REG_DATA, 32'h0);
    endtask
    task pre5;
        ex(0, fecs_pkg::UNLOCK_ADDR_A, fecs_pkg::CODE_UNLOCK_A);
        ex(0, fecs_pkg::UNLOCK_ADDR_B, fecs_pkg::CODE_UNLOCK_B);
        ex(0, fecs_pkg::UNLOCK_ADDR_A, fecs_pkg::CODE_SETUP);
        ex(0, fecs_pkg::UNLOCK_ADDR_A, fecs_pkg::CODE_UNLOCK_A);
        ex(0, fecs_pkg::UNLOCK_ADDR_B, fecs_pkg::CODE_UNLOCK_B);
    endtask
    initial
    begin
        void'($urandom(84198));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        pre5();
        ex(0, fecs_pkg::UNLOCK_ADDR_A, fecs_pkg::CODE_CHIP);
        op(fecs_pkg::OP_CHIP_ERASE, 0);
        sect = 19'($urandom);
        val = 8'($urandom) | 8'h01;
        wb(1'b1, fecs_pkg::REG_SECTOR, {13'h0, sect});
        wb(1'b1, fecs_pkg::REG_DATA, {24'h0, val});
        op(fecs_pkg::OP_READ, 1);
        chk({24'h0, q[7:0]}, {24'h0, sect[7:0] ^ 8'h5a});
        wb(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
        $display("test chip erase and read done");
        ex(1, 19'h0, fecs_pkg::CODE_BYP_PROG);
        ex(0, sect, val);
        op(fecs_pkg::OP_BYP_PROG, 0);
        ex(1, 19'h0, fecs_pkg::CODE_BYP_X1);
        ex(1, 19'h0, fecs_pkg::CODE_BYP_X2);
        op(fecs_pkg::OP_BYP_EXIT, 0);
        ex(0, sect, val);
        op(fecs_pkg::OP_WRITE_RAW, 0);
        $display("test bypass and raw write done");
        sect = 19'($urandom) & 19'h7e000;
        wb(1'b1, fecs_pkg::REG_SECTOR, {13'h0, sect});
        pre5();
        ex(0, sect, fecs_pkg::CODE_SECTOR);
        op(fecs_pkg::OP_SECT_ERASE, 0);
        sect = 19'($urandom) & 19'h7e000;
        wb(1'b1, fecs_pkg::REG_SECTOR, {13'h0, sect});
        ex(0, sect, fecs_pkg::CODE_SECTOR);
        op(fecs_pkg::OP_ADD_SECTOR, 0);
        chk({29'h0, q[2], 2'h0}, 32'h0);
        op(fecs_pkg::OP_READ, 1);
        chk({24'h0, q[7:0]}, 32'h0);
        wb(1'b1, fecs_pkg::REG_CTRL, {28'h0, fecs_pkg::OP_SUSPEND});
        ex(1, 19'h0, fecs_pkg::CODE_SUSPEND);
        op(fecs_pkg::OP_SUSPEND, 1);
        op(fecs_pkg::OP_READ, 1);
        chk({24'h0, q[7:0]}, 32'h88);
        ex(1, 19'h0, fecs_pkg::CODE_RESUME);
        op(fecs_pkg::OP_RESUME, 0);
        op(fecs_pkg::OP_READ, 0);
        chk({28'h0, q[3], 3'h0}, 32'h8);
        $display("test sector erase, suspend and resume done");
        end_sim();
    end
endmodule
